/* rtl/sweep_trig_pkg.sv */
// constants, register map and carrier types of the sweep trigger block
// assumes an apb slave view with 32-bit words and one 200 mhz clock
package sweep_trig_pkg;

   localparam int    CLK_MHZ       = 200;
   localparam int    NUM_CH        = 4;
   localparam int    CH_W          = 2;
   localparam int    DUR_W         = 16;
   localparam int    DLY_W         = 32;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_CMD     = 8'h04;
   localparam logic [7:0] OFS_STATUS  = 8'h08;
   localparam logic [7:0] OFS_GDELAY  = 8'h0c;
   localparam logic [7:0] OFS_GAUX    = 8'h10;
   localparam logic [7:0] OFS_CHDLY   = 8'h20;
   localparam logic [7:0] OFS_CHAUX   = 8'h40;

   // ctrl fields
   localparam int    CTRL_SRC_LSB  = 0;
   localparam int    CTRL_GLOBAL   = 2;
   localparam int    CTRL_POL_LSB  = 3;
   localparam int    CTRL_EARLY    = 5;
   localparam int    CTRL_CH_LSB   = 8;
   // cmd fields
   localparam int    CMD_MANUAL    = 0;
   // aux word fields
   localparam int    AUX_EN        = 0;
   localparam int    AUX_NEG       = 1;
   localparam int    AUX_AFTER     = 2;
   localparam int    AUX_POINT     = 3;
   localparam int    AUX_DUR_LSB   = 8;

   // reset values
   localparam logic [31:0] CTRL_RST  = 32'h0000_0004;
   localparam logic [DUR_W-1:0] DUR_RST = 16'h0001;
   localparam logic [DLY_W-1:0] LATENCY = 32'h0000_0002;

   typedef enum logic [1:0] {
      SRC_INTERNAL,
      SRC_MANUAL,
      SRC_EXTERNAL,
      SRC_SPARE
   } src_type;

   typedef enum logic [1:0] {
      POL_HIGH,
      POL_LOW,
      POL_RISE,
      POL_FALL
   } pol_type;

   typedef struct packed {
      logic             en;
      logic             neg;
      logic             after;
      logic             per_point;
      logic [DUR_W-1:0] dur;
   } aux_cfg_type;

   typedef struct packed {
      logic point_start;
      logic point_done;
      logic sweep_end;
   } engine_ev_type;

endpackage : sweep_trig_pkg

/* rtl/sweep_trigger_sync.sv */
// trigger qualification, sweep start delay and auxiliary output pulser
// assumes a sweep engine on pclk giving point and sweep events
//
// Behaviour
// [R1] ready_out is high while idle and the engine is prepared.
// [R2] the far instrument drives trig_in once it is itself prepared.
// [R3] sweep_done_out rises at sweep end, falls when next trigger taken.
// [R4] sweep start follows the trigger by delay plus fixed latency.
// [R5] channel scope uses that channel's delay, global scope one delay.
// [R6] level modes fire while ready and input high or low.
// [R7] rise mode fires on first rising edge after ready.
// [R8] fall mode fires on first falling edge after ready.
// [R9] early mode latches one edge, fires at ready, drops further edges.
// [R10] without early mode edges while not ready are ignored.
// [R11] early mode acts only in the edge modes.
// [R12] aux pulses only while aux enable is set, else held low whatever the polarity.
// [R13] start on internal always, manual command, or external input.
// [R14] positive polarity gives high pulse, negative a low pulse.
// [R15] before placement pulses ahead of data collection.
// [R16] after placement pulses once data collection is done.
// [R17] per point one pulse per point, else one per sweep.
// [R18] pulse stays active for the programmed duration in cycles.
// [R19] channel scope uses the swept channel's own aux settings.
// [R20] global scope takes per-point from last written channel.
// [R21] the source side should pick after placement to retune.
// [R22] triggers during a sweep start nothing new.
// [R23] trig_in is synchronised, delays counted in clock cycles.
`timescale 1ns/1ps
module sweep_trigger_sync
#(
   parameter int NUM_CH = sweep_trig_pkg::NUM_CH
)
(
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        ce,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [7:0]                  paddr,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire logic                        trig_in,
   input  wire logic                        engine_ok,
   input  wire sweep_trig_pkg::engine_ev_type engine_ev,
   output logic                             ready_out,
   output logic                             sweep_start,
   output logic                             sweep_done_out,
   output logic                             aux_out
);

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_DELAY,
      ST_SWEEP
   } state_type;

   localparam int CW = sweep_trig_pkg::CH_W;
   localparam int DW = sweep_trig_pkg::DUR_W;

   logic [31:0]                  ctrl_r;
   logic [31:0]                  gdelay_r;
   sweep_trig_pkg::aux_cfg_type  gaux_r;
   logic [31:0]                  chdly_r [NUM_CH];
   sweep_trig_pkg::aux_cfg_type  chaux_r [NUM_CH];
   logic [CW-1:0]                last_ch_r;
   logic                         manual_r;
   logic [2:0]                   sync_r;
   logic                         trig_lvl_r;
   logic                         trig_prev_r;
   logic                         early_r;
   state_type                    state_r;
   logic [31:0]                  cnt_r;
   logic [DW-1:0]                pcnt_r;
   logic                         pneg_r;

   ////////////////////////////////////////////////////////////////////
   // apb access

   function automatic logic reg_hit(input logic [7:0] a);
      logic [7:0] top;
      top = a & 8'he0;
      reg_hit = (a[1:0] == 2'h0) &&
         (a <= sweep_trig_pkg::OFS_GAUX ||
          ((top == sweep_trig_pkg::OFS_CHDLY ||
            top == sweep_trig_pkg::OFS_CHAUX) &&
           32'(a[4:2]) < NUM_CH));
   endfunction : reg_hit

   function automatic logic [31:0] aux_word(
      input sweep_trig_pkg::aux_cfg_type c);
      logic [31:0] w;
      w = 32'h0;
      w[sweep_trig_pkg::AUX_EN]    = c.en;
      w[sweep_trig_pkg::AUX_NEG]   = c.neg;
      w[sweep_trig_pkg::AUX_AFTER] = c.after;
      w[sweep_trig_pkg::AUX_POINT] = c.per_point;
      w[sweep_trig_pkg::AUX_DUR_LSB +: DW] = c.dur;
      aux_word = w;
   endfunction : aux_word

   function automatic sweep_trig_pkg::aux_cfg_type aux_cfg(
      input logic [31:0] w);
      sweep_trig_pkg::aux_cfg_type c;
      c.en        = w[sweep_trig_pkg::AUX_EN];
      c.neg       = w[sweep_trig_pkg::AUX_NEG];
      c.after     = w[sweep_trig_pkg::AUX_AFTER];
      c.per_point = w[sweep_trig_pkg::AUX_POINT];
      c.dur       = w[sweep_trig_pkg::AUX_DUR_LSB +: DW];
      aux_cfg = c;
   endfunction : aux_cfg

   logic          setup;
   logic          wr_go;
   logic [CW-1:0] wch;
   assign setup = psel && !penable;
   assign wr_go = psel && penable && pready && pwrite && !pslverr;
   assign wch   = paddr[2 +: CW];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end
      else if (ce)
      begin
         pready  <= setup;
         pslverr <= setup && !reg_hit(paddr);
         prdata  <= 32'h0;
         if (setup && !pwrite && reg_hit(paddr))
         begin
            if (paddr == sweep_trig_pkg::OFS_CTRL)
               prdata <= ctrl_r;
            else if (paddr == sweep_trig_pkg::OFS_STATUS)
               prdata <= {28'h0, early_r, trig_lvl_r,
                          state_r != ST_IDLE, ready_out};
            else if (paddr == sweep_trig_pkg::OFS_GDELAY)
               prdata <= gdelay_r;
            else if (paddr == sweep_trig_pkg::OFS_GAUX)
               prdata <= aux_word(gaux_r);
            else if ((paddr & 8'he0) == sweep_trig_pkg::OFS_CHDLY)
               prdata <= chdly_r[wch];
            else if ((paddr & 8'he0) == sweep_trig_pkg::OFS_CHAUX)
               prdata <= aux_word(chaux_r[wch]);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_r    <= sweep_trig_pkg::CTRL_RST;
         gdelay_r  <= 32'h0;
         gaux_r    <= '{1'b0, 1'b0, 1'b1, 1'b0, sweep_trig_pkg::DUR_RST};
         last_ch_r <= '0;
         manual_r  <= 1'b0;
         for (int i = 0; i < NUM_CH; i++)
         begin
            chdly_r[i] <= 32'h0;
            chaux_r[i] <= '{1'b0, 1'b0, 1'b1, 1'b0,
                            sweep_trig_pkg::DUR_RST};
         end
      end
      else if (ce)
      begin
         manual_r <= 1'b0;
         if (wr_go)
         begin
            if (paddr == sweep_trig_pkg::OFS_CTRL)
               ctrl_r <= pwdata;
            else if (paddr == sweep_trig_pkg::OFS_CMD)
               manual_r <= pwdata[sweep_trig_pkg::CMD_MANUAL];
            else if (paddr == sweep_trig_pkg::OFS_GDELAY)
               gdelay_r <= pwdata;
            else if (paddr == sweep_trig_pkg::OFS_GAUX)
               gaux_r <= aux_cfg(pwdata);
            else if ((paddr & 8'he0) == sweep_trig_pkg::OFS_CHDLY)
               chdly_r[wch] <= pwdata;
            else if ((paddr & 8'he0) == sweep_trig_pkg::OFS_CHAUX)
            begin
               chaux_r[wch] <= aux_cfg(pwdata);
               last_ch_r    <= wch; // see [R20]
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // settings in force

   sweep_trig_pkg::src_type     src;
   sweep_trig_pkg::pol_type     pol;
   logic                        glob;
   logic [CW-1:0]               cur_ch;
   logic [31:0]                 dly;
   sweep_trig_pkg::aux_cfg_type acfg;

   always_comb
   begin
      src    = sweep_trig_pkg::src_type'(ctrl_r[sweep_trig_pkg::CTRL_SRC_LSB +: 2]);
      pol    = sweep_trig_pkg::pol_type'(ctrl_r[sweep_trig_pkg::CTRL_POL_LSB +: 2]);
      glob   = ctrl_r[sweep_trig_pkg::CTRL_GLOBAL];
      cur_ch = ctrl_r[sweep_trig_pkg::CTRL_CH_LSB +: CW];
      dly    = glob ? gdelay_r : chdly_r[cur_ch]; // see [R5]
      acfg   = chaux_r[cur_ch]; // see [R19]
      if (glob)
      begin
         acfg           = gaux_r;
         acfg.per_point = chaux_r[last_ch_r].per_point; // see [R20]
      end
   end

   ////////////////////////////////////////////////////////////////////
   // trigger pin synchroniser and qualifier

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync_r      <= 3'h0;
         trig_lvl_r  <= 1'b0;
         trig_prev_r <= 1'b0;
      end
      else if (ce)
      begin
         sync_r <= {sync_r[1:0], trig_in}; // see [R23]
         if (sync_r[1] == sync_r[2])
            trig_lvl_r <= sync_r[2];
         trig_prev_r <= trig_lvl_r;
      end
   end

   logic is_edge;
   logic edge_hit;
   logic ext_fire;
   logic fire;
   assign is_edge  = (pol == sweep_trig_pkg::POL_RISE) ||
                     (pol == sweep_trig_pkg::POL_FALL);
   assign edge_hit = (pol == sweep_trig_pkg::POL_RISE) ?
                     (trig_lvl_r && !trig_prev_r) :   // see [R7]
                     (!trig_lvl_r && trig_prev_r);    // see [R8]

   always_comb
   begin
      case (pol)
         sweep_trig_pkg::POL_HIGH: ext_fire = trig_lvl_r;  // see [R6]
         sweep_trig_pkg::POL_LOW:  ext_fire = !trig_lvl_r; // see [R6]
         default:  ext_fire = edge_hit || early_r;         // see [R9]
      endcase
      case (src)
         sweep_trig_pkg::SRC_INTERNAL: fire = ready_out;   // see [R13]
         sweep_trig_pkg::SRC_MANUAL:   fire = ready_out && manual_r;
         sweep_trig_pkg::SRC_EXTERNAL: fire = ready_out && ext_fire;
         default:                      fire = 1'b0;
      endcase
   end

   // one remembered edge while not ready
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         early_r <= 1'b0;
      else if (ce)
      begin
         if (!ctrl_r[sweep_trig_pkg::CTRL_EARLY] || !is_edge) // see [R11]
            early_r <= 1'b0;
         else if (!ready_out && edge_hit) // see [R9] [R10]
            early_r <= 1'b1;
         else if (fire)
            early_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // sweep sequencing

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r        <= ST_IDLE;
         cnt_r          <= 32'h0;
         ready_out      <= 1'b0;
         sweep_start    <= 1'b0;
         sweep_done_out <= 1'b0;
      end
      else if (ce)
      begin
         sweep_start <= 1'b0;
         ready_out   <= 1'b0;
         case (state_r)
            ST_IDLE:
            begin
               ready_out <= engine_ok && !fire; // see [R1]
               if (fire)
               begin
                  state_r        <= ST_DELAY;
                  cnt_r          <= dly + sweep_trig_pkg::LATENCY; // see [R4]
                  sweep_done_out <= 1'b0;
               end
            end
            ST_DELAY:
            begin
               cnt_r <= cnt_r - 32'h1;
               if (cnt_r == 32'h1)
               begin
                  sweep_start <= 1'b1;
                  state_r     <= ST_SWEEP;
               end
            end
            ST_SWEEP:
               if (engine_ev.sweep_end) // see [R22]
               begin
                  state_r        <= ST_IDLE;
                  sweep_done_out <= 1'b1; // see [R3]
               end
            default:
               state_r <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // auxiliary output pulser

   logic pulse_ev;
   always_comb
   begin
      if (!acfg.en)
         pulse_ev = 1'b0; // see [R12]
      else if (acfg.after) // see [R16]
         pulse_ev = acfg.per_point ? engine_ev.point_done :
                    (state_r == ST_SWEEP && engine_ev.sweep_end); // see [R17]
      else // see [R15]
         pulse_ev = acfg.per_point ? engine_ev.point_start :
                    (state_r == ST_DELAY && cnt_r == 32'h1); // see [R17]
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pcnt_r  <= '0;
         pneg_r  <= 1'b0;
         aux_out <= 1'b0;
      end
      else if (ce)
      begin
         if (pulse_ev && pcnt_r == '0)
         begin
            pcnt_r  <= (acfg.dur == '0) ? DW'(1) : acfg.dur; // see [R18]
            pneg_r  <= acfg.neg;
            aux_out <= !acfg.neg; // see [R14]
         end
         else if (pcnt_r != '0)
         begin
            pcnt_r  <= pcnt_r - DW'(1);
            aux_out <= (pcnt_r == DW'(1)) ? pneg_r : !pneg_r;
         end
         else
         begin
            pneg_r  <= acfg.neg;
            aux_out <= acfg.en && acfg.neg; // see [R12]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks

   AST_READY_IDLE: // see [R1]
      assert property (@(posedge pclk) disable iff (!presetn)
         ready_out |-> $past(state_r) == ST_IDLE && $past(engine_ok))
      else $error("ready outside idle");

   AST_NO_FIRE_BUSY: // see [R22]
      assert property (@(posedge pclk) disable iff (!presetn)
         state_r != ST_IDLE |-> !fire)
      else $error("trigger taken during sweep");

   AST_START_DELAY: // see [R4]
      assert property (@(posedge pclk) disable iff (!presetn)
         ce && state_r == ST_DELAY && cnt_r == 32'h1 |=> sweep_start)
      else $error("sweep start not after delay");

   AST_DELAY_LOAD: // see [R5]
      assert property (@(posedge pclk) disable iff (!presetn)
         ce && fire |=> cnt_r == $past(dly) + sweep_trig_pkg::LATENCY)
      else $error("wrong delay loaded");

   AST_DONE_FLAG: // see [R3]
      assert property (@(posedge pclk) disable iff (!presetn)
         ce && state_r == ST_SWEEP && engine_ev.sweep_end
         |=> sweep_done_out && state_r == ST_IDLE)
      else $error("sweep done not shown");

   AST_EDGE_ONLY: // see [R11]
      assert property (@(posedge pclk) disable iff (!presetn)
         ce && !is_edge |=> !early_r)
      else $error("early latch in level mode");

   AST_NO_EARLY_OFF: // see [R10]
      assert property (@(posedge pclk) disable iff (!presetn)
         ce && !ctrl_r[sweep_trig_pkg::CTRL_EARLY] |=> !early_r)
      else $error("early latch while disabled");

   AST_AUX_IDLE: // see [R12]
      assert property (@(posedge pclk) disable iff (!presetn)
         (!acfg.en && pcnt_r == '0) [*2] |=> aux_out == 1'b0)
      else $error("aux active while disabled");

   AST_PULSE_LEN: // see [R18]
      assert property (@(posedge pclk) disable iff (!presetn)
         ce && pulse_ev && pcnt_r == '0 && acfg.dur == DW'(2)
         ##1 ce |=> aux_out == !pneg_r ##1 aux_out == pneg_r)
      else $error("pulse length wrong");

   AST_POLARITY: // see [R14]
      assert property (@(posedge pclk) disable iff (!presetn)
         ce && pulse_ev && pcnt_r == '0 |=> aux_out == !$past(acfg.neg))
      else $error("pulse polarity wrong");

endmodule : sweep_trigger_sync

/* sim/trig_partner.sv */
// far instrument driving the trigger pin, plus a small sweep engine
// assumes the device outputs on pclk and a bench that requests pulses
`timescale 1ns/1ps
module trig_partner
(
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   input  wire logic                          ready_out,
   input  wire logic                          sweep_start,
   input  wire logic                          pulse_req,
   input  wire logic                          wait_rdy,
   input  wire logic                          base,
   input  wire logic [3:0]                    npts,
   output logic                               trig_in,
   output sweep_trig_pkg::engine_ev_type      engine_ev
);
   logic       pend_r;
   logic [2:0] pw_r;
   logic       run_r;
   logic [1:0] t_r;
   logic [3:0] left_r;
   logic       end_r;

   ////////////////////////////////////////////////////////////////////////
   // trigger pin, four cycle pulse away from the idle level
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pend_r  <= 1'b0;
         pw_r    <= 3'h0;
         trig_in <= base;
      end
      else if (pw_r != 3'h0)
      begin
         pw_r    <= pw_r - 3'h1;
         trig_in <= (pw_r == 3'h1) ? base : ~base;
      end
      else if ((pulse_req || pend_r) && (!wait_rdy || ready_out))
      begin
         pend_r  <= 1'b0;
         pw_r    <= 3'h4;
         trig_in <= ~base;
      end
      else
      begin
         pend_r  <= pend_r | pulse_req;
         trig_in <= base;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sweep engine, one point every four cycles
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         run_r  <= 1'b0;
         t_r    <= 2'h0;
         left_r <= 4'h0;
         end_r  <= 1'b0;
      end
      else
      begin
         end_r <= run_r && (t_r == 2'h3) && (left_r == 4'h1);
         if (sweep_start)
         begin
            run_r  <= 1'b1;
            t_r    <= 2'h0;
            left_r <= npts;
         end
         else if (run_r)
         begin
            t_r <= t_r + 2'h1;
            if (t_r == 2'h3)
            begin
               left_r <= left_r - 4'h1;
               run_r  <= (left_r != 4'h1);
            end
         end
      end
   end

   assign engine_ev = {run_r && (t_r == 2'h1), run_r && (t_r == 2'h3), end_r};

endmodule : trig_partner

/* sim/sweep_trigger_sync_tb.sv */
// self-checking bench of the sweep trigger block
// assumes the partner model in trig_partner and apb access only
`timescale 1ns/1ps
module sweep_trigger_sync_tb;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        trig_in;
   logic        ready_out;
   logic        sweep_start;
   logic        sweep_done_out;
   logic        aux_out;
   logic        pulse_req;
   logic        wait_rdy;
   logic        base;
   logic [3:0]  npts;
   logic        aux_idle;
   logic        aux_q;
   logic        engine_ok;
   logic [31:0] rd;
   logic        err;
   int          n_fail;
   int          checked;
   int          n_start;
   int          aux_act;
   int          aux_pul;
   int          cyc;
   int          lat_a;
   int          lat_b;
   sweep_trig_pkg::engine_ev_type engine_ev;
   logic [31:0] g_tab [4];
   int          pt_tab [4];
   int          ep_tab [4];
   int          ea_tab [4];
   int          pol_tab [6];
   int          ear_tab [6];

   sweep_trigger_sync u_sweep_trigger_sync (.pclk(pclk), .presetn(presetn),
      .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .trig_in(trig_in), .engine_ok(engine_ok),
      .engine_ev(engine_ev), .ready_out(ready_out),
      .sweep_start(sweep_start), .sweep_done_out(sweep_done_out),
      .aux_out(aux_out));

   trig_partner u_trig_partner (.pclk(pclk), .presetn(presetn),
      .ready_out(ready_out), .sweep_start(sweep_start),
      .pulse_req(pulse_req), .wait_rdy(wait_rdy), .base(base),
      .npts(npts), .trig_in(trig_in), .engine_ev(engine_ev));

   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   ////////////////////////////////////////////////////////////////////////
   // monitors and hang guard
   always @(posedge pclk)
   begin
      cyc++;
      if (sweep_start === 1'b1) n_start++;
      if (aux_out !== aux_idle) aux_act++;
      if (aux_out !== aux_idle && aux_q === aux_idle) aux_pul++;
      aux_q = aux_out;
      if (cyc == 20000)
      begin
         n_fail++;
         $display("FAIL %0t run timed out", $time);
         complete_run();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // tasks
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : cmp

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic sweep(output int lat);
      lat = 0;
      apb(1'b1, sweep_trig_pkg::OFS_CMD, 32'h1);
      while (sweep_start !== 1'b1)
      begin
         @(posedge pclk);
         lat++;
      end
      cmp({31'h0, sweep_done_out}, 32'h0, "done during sweep");
      while (ready_out !== 1'b1) @(posedge pclk);
      repeat (8) @(posedge pclk);
      cmp({31'h0, sweep_done_out}, 32'h1, "done after sweep");
   endtask : sweep

   function automatic logic [31:0] ctl(input int s, g, p, e, c);
      return 32'(s + (g << 2) + (p << 3) + (e << 5) + (c << 8));
   endfunction : ctl

   function automatic logic [31:0] aux(input int en, ng, af, pt, du);
      return 32'(en + ng * 2 + af * 4 + pt * 8 + (du << 8));
   endfunction : aux

   task automatic complete_run;
      $display("counts: checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pulse_req = 1'b0;
      wait_rdy = 1'b1;
      base = 1'b0;
      npts = 4'h3;
      aux_idle = 1'b0;
      aux_q = 1'b0;
      engine_ok = 1'b1;
      g_tab = '{aux(1,0,0,0,4), aux(1,1,1,0,3), aux(1,0,0,0,2), aux(0,0,0,0,4)};
      pt_tab = '{0, 1, 1, 1};
      ep_tab = '{1, 3, 3, 0};
      ea_tab = '{4, 9, 6, 0};
      pol_tab = '{2, 3, 2, 3, 0, 1};
      ear_tab = '{0, 0, 1, 1, 1, 1};
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, sweep_trig_pkg::OFS_CTRL, 32'h0);
      cmp(rd, sweep_trig_pkg::CTRL_RST, "ctrl reset");
      apb(1'b0, sweep_trig_pkg::OFS_GAUX, 32'h0);
      cmp(rd, 32'h0000_0104, "aux reset");
      apb(1'b0, 8'h14, 32'h0);
      cmp({31'h0, err}, 32'h1, "unmapped error");
      apb(1'b1, sweep_trig_pkg::OFS_CTRL, ctl(1, 1, 0, 0, 0));
      while (ready_out !== 1'b1) @(posedge pclk);
      apb(1'b0, sweep_trig_pkg::OFS_STATUS, 32'h0);
      cmp(rd & 32'h3, 32'h1, "ready status");
      engine_ok <= 1'b0;
      repeat (2) @(posedge pclk);
      cmp({31'h0, ready_out}, 32'h0, "ready without engine");
      engine_ok <= 1'b1;
      $display("test registers done");
      apb(1'b1, sweep_trig_pkg::OFS_GDELAY, 32'h3);
      sweep(lat_a);
      apb(1'b1, sweep_trig_pkg::OFS_GDELAY, 32'h9);
      sweep(lat_b);
      cmp(32'(lat_b - lat_a), 32'h6, "global delay");
      apb(1'b1, sweep_trig_pkg::OFS_CHDLY + 8'h4, 32'h14);
      apb(1'b1, sweep_trig_pkg::OFS_CTRL, ctl(1, 0, 0, 0, 1));
      sweep(lat_b);
      cmp(32'(lat_b - lat_a), 32'h11, "channel delay");
      $display("test delay done");
      apb(1'b1, sweep_trig_pkg::OFS_CTRL, ctl(1, 1, 0, 0, 0));
      for (int i = 0; i < 4; i++)
      begin
         // after placement entry is what a retuning source wants
         apb(1'b1, sweep_trig_pkg::OFS_GAUX, g_tab[i]);
         apb(1'b1, sweep_trig_pkg::OFS_CHAUX + 8'h4, 32'((1 - pt_tab[i]) * 8));
         apb(1'b1, sweep_trig_pkg::OFS_CHAUX, 32'(pt_tab[i] * 8));
         aux_idle <= g_tab[i][0] & g_tab[i][1];
         repeat (3) @(posedge pclk);
         cmp({31'h0, aux_out}, {31'h0, aux_idle}, "aux idle");
         aux_act = 0;
         aux_pul = 0;
         sweep(lat_a);
         cmp(32'(aux_pul), 32'(ep_tab[i]), "aux pulses");
         cmp(32'(aux_act), 32'(ea_tab[i]), "aux width");
      end
      apb(1'b1, sweep_trig_pkg::OFS_CTRL, ctl(1, 0, 0, 0, 2));
      apb(1'b1, sweep_trig_pkg::OFS_CHAUX + 8'h8, aux(1, 0, 1, 0, 5));
      aux_idle <= 1'b0;
      aux_act = 0;
      sweep(lat_a);
      cmp(32'(aux_act), 32'h5, "channel aux set");
      $display("test aux done");
      apb(1'b1, sweep_trig_pkg::OFS_GDELAY, 32'h2);
      npts = 4'h8;
      for (int i = 0; i < 6; i++)
      begin
         apb(1'b1, sweep_trig_pkg::OFS_CTRL, ctl(1, 1, pol_tab[i], 0, 0));
         base <= (pol_tab[i] == 1 || pol_tab[i] == 3);
         repeat (10) @(posedge pclk);
         n_start = 0;
         apb(1'b1, sweep_trig_pkg::OFS_CTRL,
             ctl(2, 1, pol_tab[i], ear_tab[i], 0));
         repeat (10) @(posedge pclk);
         cmp(32'(n_start), 32'h0, "idle level fired");
         wait_rdy <= 1'b1;
         pulse_req <= 1'b1;
         @(posedge pclk);
         pulse_req <= 1'b0;
         while (ready_out !== 1'b0) @(posedge pclk);
         repeat (6) @(posedge pclk);
         wait_rdy <= 1'b0;
         pulse_req <= 1'b1;
         @(posedge pclk);
         pulse_req <= 1'b0;
         repeat (8) @(posedge pclk);
         pulse_req <= 1'b1;
         @(posedge pclk);
         pulse_req <= 1'b0;
         while (ready_out !== 1'b1) @(posedge pclk);
         repeat (40) @(posedge pclk);
         cmp(32'(n_start), (ear_tab[i] == 1 && pol_tab[i] >= 2) ? 32'h2 : 32'h1,
             "trigger count");
         while (ready_out !== 1'b1) @(posedge pclk);
      end
      $display("test trigger modes done");
      apb(1'b1, sweep_trig_pkg::OFS_CTRL, ctl(0, 1, 0, 0, 0));
      n_start = 0;
      repeat (200) @(posedge pclk);
      apb(1'b1, sweep_trig_pkg::OFS_CTRL, ctl(1, 1, 0, 0, 0));
      while (ready_out !== 1'b1) @(posedge pclk);
      cmp(32'(n_start >= 3), 32'h1, "internal source");
      $display("test internal done");
      complete_run();
   end

endmodule : sweep_trigger_sync_tb
